//--- eeprom_chk.sv
// Concurrent checks on the two-wire link and on the programming busy flag.
`timescale 1ns/100ps
module eeprom_chk #(
    parameter int PHASE_CYCLES = eeprom_pkg::PHASE_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic O_PROG_BUSY
);
    logic sda_q_r;
    logic [7:0] since_stop_r;
    logic [31:0] busy_cnt_r;

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    // Track the age of the last stop seen on the wire; saturates so idle time never wraps.
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            sda_q_r <= 1'b1;
            since_stop_r <= 8'hFF;
            busy_cnt_r <= '0;
        end else begin
            sda_q_r <= sda;
            if (scl && sda && !sda_q_r) begin
                since_stop_r <= 8'h00;
            end else if (since_stop_r != 8'hFF) begin
                since_stop_r <= since_stop_r + 8'h01;
            end
            busy_cnt_r <= O_PROG_BUSY ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    AST_SCL_HIGH_MIN: assert property ($rose(scl) |=> scl [*8])
        else $error("bus clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |=> !scl [*8])
        else $error("bus clock low phase too short");
    AST_DEV_EDGE_ON_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("device changed its data drive while the bus clock was high");
    AST_ONE_TALKER: assert property ($rose(scl) |-> !(host_sda_oe && dev_sda_oe))
        else $error("both ends drive data at a bus clock rise");
    AST_STOP_RELEASES: assert property (scl && $rose(sda) |=> !dev_sda_oe [*4])
        else $error("device drives data after a stop");
    AST_BUSY_ON_STOP: assert property ($rose(O_PROG_BUSY) |-> since_stop_r < 8'h10)
        else $error("programming began without a recent stop");
    AST_BUSY_MIN: assert property ($rose(O_PROG_BUSY) |=> O_PROG_BUSY [*8])
        else $error("programming busy flag dropped at once");
    AST_BUSY_BOUND: assert property (busy_cnt_r <= 2 * PHASE_CYCLES + 2)
        else $error("programming cycle ran past its bound");
endmodule

//--- eeprom_dev.sv
// EEPROM end of the link: bus sequencing, select matching, array and self-timed programming.
//
// Function
// - SDA fall/rise with SCL high: start/stop.
// - Acknowledge low from eighth fall through ninth.
// - Release SDA on ninth clock when reading.
// - Master sends three bytes after start.
// - Master clocks whole data byte before stop.
// - Programming starts on stop after 27th clock.
// - Select only when select bit matches pin.
// - Write-select during programming aborts programming.
// - Ignore read-select while programming is busy.
// - Read: write-select, address, restart, read-select.
// - Load byte on clock nine, drive after.
// - One more data bit each shift clock.
// - Master acknowledge increments the address counter.
// - Address counter never wraps to zero.
// - Stop releases SDA and idles read logic.
// - Erase word to ones, then clear zeros.
// - Erase plus write lasts under twenty ms.
// - Skip write for FF, erase when erased; the code skips the erase when the word already reads FF.
// - SDA released after power-up until read.
// - Master should first do an address read.
// - Stop resets control, except starting programming.
// - Erase pin plus FF at zero erases array.
// - Select word layouts for write and read.
`timescale 1ns/100ps
module eeprom_dev #(
    parameter int PHASE_CYCLES = eeprom_pkg::PHASE_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_CS_PIN,
    input wire logic I_ARRAY_ERASE_ENABLE_PIN,
    eeprom_link_if.dev LINK,
    output logic O_PROG_BUSY
);
    import eeprom_pkg::*;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic cs_m;
        logic cs_s;
        logic ee_m;
        logic ee_s;
        bus_phase_t ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [8:0] addr;
        logic [7:0] wdat;
        logic drv;
        logic first;
        logic armed;
        prog_phase_t pg;
        logic chip;
        logic [TMR_W-1:0] tmr;
        logic busy;
    } dev_state_t;

    logic [7:0] mem [0:MEM_DEPTH-1];
    dev_state_t r;
    dev_state_t n;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [ADDR_W-1:0] addr_inc;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic active;
    logic sel_ok;

    // Next-state logic for the whole end; the programming engine runs first so that
    // bus events later in the process can override it.
    always_comb begin
        n = r;
        mem_we = 1'b0;
        mem_waddr = r.addr;
        mem_wdata = ERASED;
        n.scl_m = LINK.scl;
        n.scl_s = r.scl_m;
        n.scl_d = r.scl_s;
        n.sda_m = LINK.sda;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;
        n.cs_m = I_CS_PIN;
        n.cs_s = r.cs_m;
        n.ee_m = I_ARRAY_ERASE_ENABLE_PIN;
        n.ee_s = r.ee_m;
        rise = r.scl_s & ~r.scl_d;
        fall = ~r.scl_s & r.scl_d;
        start_c = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
        stop_c = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
        active = (r.ph != PH_IDLE) && (r.ph != PH_IGNORE);
        addr_inc = (r.addr == LAST_ADDR) ? r.addr : r.addr + 1'b1;
        sel_ok = (r.sh[7:4] == SEL_TAG) && (r.sh[SEL_CS_BIT] == r.cs_s);

        // Self-timed erase then write; each phase is one timer run.
        case (r.pg)
            PG_ERASE: begin
                // A chip erase sweeps the array with the low timer bits, so the phase
                // must last at least one cycle per word.
                if (r.chip) begin
                    mem_we = 1'b1;
                    mem_waddr = r.tmr[ADDR_W-1:0];
                end
                n.tmr = r.tmr + 1'b1;
                if (r.tmr == TMR_W'(PHASE_CYCLES - 1)) begin
                    if (!r.chip) begin
                        mem_we = 1'b1;
                        mem_waddr = r.addr;
                    end
                    n.tmr = '0;
                    if (r.chip || r.wdat == ERASED) begin
                        n.pg = PG_IDLE;
                        n.busy = 1'b0;
                    end else begin
                        n.pg = PG_WRITE;
                    end
                end
            end
            PG_WRITE: begin
                n.tmr = r.tmr + 1'b1;
                if (r.tmr == TMR_W'(PHASE_CYCLES - 1)) begin
                    // The word is all ones here, so storing the data clears just its zeros.
                    mem_we = 1'b1;
                    mem_wdata = r.wdat;
                    n.pg = PG_IDLE;
                    n.busy = 1'b0;
                    n.tmr = '0;
                end
            end
            default: begin
            end
        endcase

        // Bus sequencing: start and stop outrank clock edges.
        if (start_c) begin
            n.ph = PH_SEL;
            n.cnt = '0;
            n.drv = 1'b0;
            n.armed = 1'b0;
            n.first = 1'b0;
        end else if (stop_c) begin
            n.ph = PH_IDLE;
            n.drv = 1'b0;
            n.cnt = '0;
            n.armed = 1'b0;
            n.first = 1'b0;
            if (r.armed) begin
                n.tmr = '0;
                n.chip = r.ee_s && (r.addr == ZERO_ADDR) && (r.wdat == ERASED);
                if (n.chip || mem[r.addr] != ERASED) begin
                    n.pg = PG_ERASE;
                    n.busy = 1'b1;
                end else if (r.wdat != ERASED) begin
                    n.pg = PG_WRITE;
                    n.busy = 1'b1;
                end
            end
        end else if (fall && r.ph == PH_IGNORE) begin
            // Any clock beyond the 27th means the write is not to be started; it is
            // counted at its fall, since the rise that sets up a stop is no extra clock.
            n.armed = 1'b0;
        end else if (rise && active) begin
            if (r.cnt < CNT_ACK) begin
                if (r.ph != PH_READ) begin
                    n.sh = {r.sh[6:0], r.sda_s};
                end
                n.cnt = r.cnt + 1'b1;
            end else begin
                n.cnt = CNT_END;
                if (r.ph == PH_READ && r.first) begin
                    n.sh = mem[r.addr];
                    n.first = 1'b0;
                end else if (r.ph == PH_READ && !r.sda_s) begin
                    n.addr = addr_inc;
                    n.sh = mem[addr_inc];
                end else if (r.ph == PH_READ) begin
                    n.ph = PH_IGNORE; // Master declined; stay off the line until stop.
                end
            end
        end else if (fall && active) begin
            if (r.cnt == CNT_ACK) begin
                case (r.ph)
                    PH_SEL: begin
                        if (!sel_ok) begin
                            n.ph = PH_IGNORE;
                        end else if (!r.sh[SEL_RW_BIT] && !r.sh[SEL_ZERO_BIT]) begin
                            n.drv = 1'b1;
                            n.addr[8] = r.sh[SEL_MSB_BIT];
                            n.pg = PG_IDLE;
                            n.busy = 1'b0;
                        end else if (r.sh[SEL_RW_BIT] && !r.busy) begin
                            n.drv = 1'b1;
                            n.ph = PH_READ;
                            n.first = 1'b1;
                        end else begin
                            n.ph = PH_IGNORE;
                        end
                    end
                    PH_ADDR: begin
                        n.addr[7:0] = r.sh;
                        n.drv = 1'b1;
                    end
                    PH_DATA: begin
                        n.wdat = r.sh;
                        n.drv = 1'b1;
                    end
                    default: begin
                        n.drv = 1'b0;
                    end
                endcase
            end else if (r.cnt == CNT_END) begin
                n.cnt = '0;
                n.drv = 1'b0;
                if (r.ph == PH_READ) begin
                    n.drv = ~r.sh[7];
                end else if (r.ph == PH_SEL) begin
                    n.ph = PH_ADDR; // Write phases advance only once the ack clock is over.
                end else if (r.ph == PH_ADDR) begin
                    n.ph = PH_DATA;
                end else if (r.ph == PH_DATA) begin
                    n.armed = 1'b1;
                    n.ph = PH_IGNORE;
                end
            end else if (r.ph == PH_READ) begin
                n.sh = {r.sh[6:0], 1'b1};
                n.drv = ~r.sh[6];
            end
        end
    end

    // State register; reset leaves SDA released and the engine idle.
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            r <= '0;
        end else if (I_CE) begin
            r <= n;
        end
    end

    // The array is nonvolatile, so it takes no reset.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_CE && mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    assign LINK.dev_sda_oe = r.drv;
    assign LINK.dev_sda_o = 1'b0;
    assign O_PROG_BUSY = r.busy;
endmodule

//--- eeprom_host.sv
// Host end of the link: makes the bus clock and runs write, read and poll sequences.
`timescale 1ns/100ps
module eeprom_host (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_START,
    input wire logic [1:0] I_OP,
    input wire logic I_CS,
    input wire logic [8:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    eeprom_link_if.host LINK,
    output logic O_BUSY,
    output logic O_DONE,
    output logic O_NACK,
    output logic [7:0] O_RDATA
);
    import eeprom_pkg::*;

    typedef struct packed {
        logic sda_m;
        logic sda_s;
        host_state_t st;
        logic [1:0] op;
        logic cs;
        logic [8:0] addr;
        logic [7:0] wdat;
        logic [2:0] step;
        logic [1:0] q;
        logic [DIV_W-1:0] div;
        logic [3:0] cnt;
        logic [7:0] tx;
        step_kind_t kind;
        logic [7:0] rx;
        logic scl;
        logic sda_lo;
        logic busy;
        logic done;
        logic nack;
    } host_state_s_t;

    host_state_s_t r;
    host_state_s_t n;
    step_t nxt;
    logic tick;

    // Step table for each operation; the read repeats the start before the read-select.
    function automatic step_t step_of(input logic [1:0] op, input logic [2:0] idx,
                                      input logic cs, input logic [8:0] a,
                                      input logic [7:0] d);
        step_t s;
        logic [7:0] selw;
        logic [7:0] selr;
        selw = {SEL_TAG, 1'b0, a[8], cs, 1'b0};
        selr = {SEL_TAG, 2'b00, cs, 1'b1};
        s.kind = K_STOP;
        s.data = ERASED;
        if (op == OP_WRITE) begin
            case (idx)
                3'h0: s.kind = K_START;
                3'h1: s = '{K_TX, selw};
                3'h2: s = '{K_TX, a[7:0]};
                3'h3: s = '{K_TX, d};
                default: s.kind = K_STOP;
            endcase
        end else if (op == OP_READ) begin
            case (idx)
                3'h0: s.kind = K_START;
                3'h1: s = '{K_TX, selw};
                3'h2: s = '{K_TX, a[7:0]};
                3'h3: s.kind = K_START;
                3'h4: s = '{K_TX, selr};
                3'h5: s.kind = K_RX;
                default: s.kind = K_STOP;
            endcase
        end else begin
            case (idx)
                3'h0: s.kind = K_START;
                3'h1: s = '{K_TX, selr};
                3'h2: s.kind = K_RX;
                default: s.kind = K_STOP;
            endcase
        end
        return s;
    endfunction

    // One quarter of the bus clock per tick; actions run at the end of each quarter.
    always_comb begin
        n = r;
        n.sda_m = LINK.sda;
        n.sda_s = r.sda_m;
        n.done = 1'b0;
        tick = (r.div == DIV_W'(SCL_QTR_CYCLES - 1));
        nxt = step_of(r.op, r.step + 3'h1, r.cs, r.addr, r.wdat);
        if (r.st != HS_IDLE) begin
            n.div = tick ? '0 : r.div + 1'b1;
        end
        case (r.st)
            HS_IDLE: begin
                n.div = '0;
                n.q = '0;
                if (I_START) begin
                    n.op = I_OP;
                    n.cs = I_CS;
                    n.addr = I_ADDR;
                    n.wdat = I_WDATA;
                    n.step = '0;
                    n.st = HS_START;
                    n.sda_lo = 1'b0;
                    n.busy = 1'b1;
                    n.nack = 1'b0;
                end
            end
            HS_START: begin
                if (tick) begin
                    n.q = r.q + 1'b1;
                    case (r.q)
                        2'h0: n.scl = 1'b1;
                        2'h1: n.sda_lo = 1'b1;
                        2'h2: n.scl = 1'b0;
                        default: begin
                            n.step = r.step + 3'h1;
                            n.kind = nxt.kind;
                            n.tx = nxt.data;
                            n.cnt = '0;
                            n.st = HS_BYTE;
                        end
                    endcase
                end
            end
            HS_BYTE: begin
                if (tick) begin
                    n.q = r.q + 1'b1;
                    case (r.q)
                        2'h0: n.sda_lo = (r.kind == K_TX) && (r.cnt < CNT_ACK) && !r.tx[7];
                        2'h1: n.scl = 1'b1;
                        2'h2: begin
                            if (r.cnt < CNT_ACK) begin
                                n.rx = {r.rx[6:0], r.sda_s};
                            end else if (r.kind == K_TX && r.sda_s) begin
                                n.nack = 1'b1;
                            end
                        end
                        default: begin
                            n.scl = 1'b0;
                            n.tx = {r.tx[6:0], 1'b1};
                            n.cnt = r.cnt + 1'b1;
                            if (r.cnt == CNT_ACK) begin
                                n.step = r.step + 3'h1;
                                n.kind = nxt.kind;
                                n.tx = nxt.data;
                                n.cnt = '0;
                                if (r.kind == K_RX) begin
                                    n.st = HS_STOP; // Single byte; the ack bit stays high.
                                end else if (r.nack) begin
                                    n.st = HS_STOP; // A refused byte ends the transfer.
                                end else if (nxt.kind == K_START) begin
                                    n.st = HS_START;
                                end else if (nxt.kind == K_STOP) begin
                                    n.st = HS_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                if (tick) begin
                    n.q = r.q + 1'b1;
                    case (r.q)
                        2'h0: n.sda_lo = 1'b1;
                        2'h1: n.scl = 1'b1;
                        2'h2: n.sda_lo = 1'b0;
                        default: begin
                            n.st = HS_IDLE;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    endcase
                end
            end
            default: n.st = HS_IDLE;
        endcase
    end

    // State register; the bus lines idle high from reset.
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            r <= '0;
            r.scl <= 1'b1;
        end else if (I_CE) begin
            r <= n;
        end
    end

    assign LINK.scl = r.scl;
    assign LINK.host_sda_oe = r.sda_lo;
    assign LINK.host_sda_o = 1'b0;
    assign O_BUSY = r.busy;
    assign O_DONE = r.done;
    assign O_NACK = r.nack;
    assign O_RDATA = r.rx;
endmodule

//--- eeprom_link_if.sv
// Two-wire link between the host end and the EEPROM end.
`timescale 1ns/100ps
interface eeprom_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open-drain wired AND with a pull-up: any enabled low driver wins.
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

//--- eeprom_pkg.sv
// Shared constants and types for the serial EEPROM link and both of its ends.
package eeprom_pkg;
    // Array organisation.
    localparam int MEM_DEPTH = 512;
    localparam int ADDR_W = 9;
    localparam logic [8:0] LAST_ADDR = 9'h1FF;
    localparam logic [8:0] ZERO_ADDR = 9'h000;
    localparam logic [7:0] ERASED = 8'hFF;

    // Select word layout: tag in the top nibble, then the low bits.
    localparam logic [3:0] SEL_TAG = 4'hA;
    localparam int SEL_ZERO_BIT = 3;
    localparam int SEL_MSB_BIT = 2;
    localparam int SEL_CS_BIT = 1;
    localparam int SEL_RW_BIT = 0;

    // Bit counter marks: after the eighth data clock and after the ack clock.
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_END = 4'h9;

    // Core clock and self-timed programming phases.
    localparam int CLK_PERIOD_NS = 100;
    localparam int PHASE_TIME_US = 5000;
    localparam int PHASE_CYCLES = (PHASE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TMR_W = 17;

    // Link clock made by the host: 100 kHz, split into four quarters.
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QTR_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 5;

    // Host operation codes.
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_POLL = 2'h2;

    typedef enum logic [2:0] {PH_IDLE, PH_SEL, PH_ADDR, PH_DATA, PH_READ, PH_IGNORE} bus_phase_t;
    typedef enum logic [1:0] {PG_IDLE, PG_ERASE, PG_WRITE} prog_phase_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} host_state_t;
    typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} step_kind_t;

    typedef struct packed {
        step_kind_t kind;
        logic [7:0] data;
    } step_t;
endpackage

//--- tb.sv
// Self-checking bench: host and EEPROM ends joined over one link, results checked from a queue.
`timescale 1ns/100ps
module tb;
    import eeprom_pkg::*;
    localparam int PH = 1200;
    typedef struct packed {
        logic nack;
        logic chk;
        logic [7:0] data;
    } note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cs_pin = 1'b0;
    logic erase_pin = 1'b0;
    logic start = 1'b0;
    logic [1:0] op = OP_READ;
    logic cs = 1'b0;
    logic [8:0] addr = ZERO_ADDR;
    logic [7:0] wdata = ERASED;
    logic busy, done, nack, prog_busy;
    logic [7:0] rdata;
    note_t notes[$];
    note_t got;
    int n_fail = 0;
    int checks_done = 0;
    integer seed = 61397;
    logic [8:0] a;
    logic [7:0] d1, d2;

    eeprom_link_if link();
    eeprom_dev #(.PHASE_CYCLES(PH)) i_eeprom_dev (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce),
        .I_CS_PIN(cs_pin), .I_ARRAY_ERASE_ENABLE_PIN(erase_pin), .LINK(link.dev),
        .O_PROG_BUSY(prog_busy));
    eeprom_host i_eeprom_host (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_START(start),
        .I_OP(op), .I_CS(cs), .I_ADDR(addr), .I_WDATA(wdata), .LINK(link.host),
        .O_BUSY(busy), .O_DONE(done), .O_NACK(nack), .O_RDATA(rdata));
    eeprom_chk #(.PHASE_CYCLES(PH)) i_eeprom_chk (.I_CORE_CLK(clk), .I_RST(rst),
        .scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
        .dev_sda_oe(link.dev_sda_oe), .O_PROG_BUSY(prog_busy));

    // Core clock, 100 ns period.
    always #50 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One host operation; the expected outcome is queued before the request goes out.
    task automatic run(input logic [1:0] o, input logic c, input logic [8:0] ad,
                       input logic [7:0] d, input logic en, input logic ch, input logic [7:0] ex);
        int k;
        @(negedge clk);
        op = o;
        cs = c;
        addr = ad;
        wdata = d;
        start = 1'b1;
        notes.push_back('{nack: en, chk: ch, data: ex});
        @(negedge clk);
        start = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 20000) begin
            @(negedge clk);
            k++;
        end
        check({7'h00, busy}, 8'h00);
        repeat (8) @(negedge clk);
    endtask

    // Busy rises a few cycles after the stop, so let it land before waiting on it.
    task automatic wait_prog();
        int k;
        repeat (5) @(negedge clk);
        k = 0;
        while (prog_busy !== 1'b0 && k < 4 * PH) begin
            @(negedge clk);
            k++;
        end
        check({7'h00, prog_busy}, 8'h00);
    endtask

    // Each finished host operation retires the oldest note.
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                check(8'h01, 8'h00);
            end else begin
                got = notes.pop_front();
                check({7'h00, nack}, {7'h00, got.nack});
                if (got.chk) begin
                    check(rdata, got.data);
                end
            end
        end
    end

    // Main sequence: erase the array, then program, poll, refuse, abort and read back.
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({6'h00, link.scl, link.sda}, 8'h03);
        run(OP_READ, 1'b0, ZERO_ADDR, ERASED, 1'b0, 1'b0, ERASED);
        erase_pin = 1'b1;
        run(OP_WRITE, 1'b0, ZERO_ADDR, ERASED, 1'b0, 1'b0, ERASED);
        wait_prog();
        erase_pin = 1'b0;
        a = 9'($random(seed));
        d1 = 8'($random(seed)) & 8'h7F;
        d2 = 8'($random(seed)) & 8'hFE;
        run(OP_READ, 1'b0, a, ERASED, 1'b0, 1'b1, ERASED);
        cs_pin = 1'b1;
        run(OP_WRITE, 1'b1, a, d1, 1'b0, 1'b0, d1);
        wait_prog();
        run(OP_READ, 1'b1, a, d1, 1'b0, 1'b1, d1);
        // Overwriting a programmed word runs both phases, long enough for a busy poll.
        run(OP_WRITE, 1'b1, a, d2, 1'b0, 1'b0, d2);
        run(OP_POLL, 1'b1, a, d2, 1'b1, 1'b0, d2);
        wait_prog();
        run(OP_POLL, 1'b1, a, d2, 1'b0, 1'b1, d2);
        run(OP_READ, 1'b1, a, d2, 1'b0, 1'b1, d2);
        run(OP_WRITE, 1'b0, a, 8'h00, 1'b1, 1'b0, d2);
        run(OP_READ, 1'b0, a, d2, 1'b1, 1'b0, d2);
        run(OP_READ, 1'b1, a, d2, 1'b0, 1'b1, d2);
        // A second write during programming cuts the first short and programs its own byte.
        run(OP_WRITE, 1'b1, a, d1, 1'b0, 1'b0, d1);
        run(OP_WRITE, 1'b1, a, d2, 1'b0, 1'b0, d2);
        wait_prog();
        run(OP_READ, 1'b1, a, d2, 1'b0, 1'b1, d2);
        run(OP_WRITE, 1'b1, a, ERASED, 1'b0, 1'b0, ERASED);
        wait_prog();
        run(OP_READ, 1'b1, a, ERASED, 1'b0, 1'b1, ERASED);
        check(8'(notes.size()), 8'h00);
        conclude();
    end

    // Watchdog: the sequence needs roughly 60k cycles, so 100k means a hang.
    initial begin
        #(10_000_000);
        n_fail++;
        conclude();
    end
endmodule
